// *** rtl/switcher_pkg.sv ***
package switcher_pkg;

    // timebase and switching rates
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned FULL_FREQ_HI_HZ = 132_000;
    localparam int unsigned FULL_FREQ_LO_HZ = 66_000;
    localparam int unsigned MIN_FREQ_HZ = 30_000;
    localparam int unsigned JITTER_HI_HZ = 5_000;
    localparam int unsigned JITTER_LO_HZ = 2_500;
    localparam int unsigned JITTER_RATE_HZ = 250;
    localparam int unsigned SOFT_START_MS = 17;

    localparam int unsigned PERIOD_W = 11;
    localparam logic [10:0] PERIOD_HI = 11'(CLK_HZ / FULL_FREQ_HI_HZ);
    localparam logic [10:0] PERIOD_LO = 11'(CLK_HZ / FULL_FREQ_LO_HZ);
    localparam logic [10:0] PERIOD_MIN_FREQ = 11'(CLK_HZ / MIN_FREQ_HZ);
    localparam logic [10:0] JIT_DEV_HI = 11'(CLK_HZ / (FULL_FREQ_HI_HZ - JITTER_HI_HZ) - CLK_HZ / FULL_FREQ_HI_HZ);
    localparam logic [10:0] JIT_DEV_LO = 11'(CLK_HZ / (FULL_FREQ_LO_HZ - JITTER_LO_HZ) - CLK_HZ / FULL_FREQ_LO_HZ);
    localparam int unsigned JITTER_CYCLES = CLK_HZ / JITTER_RATE_HZ;
    localparam int unsigned SOFT_START_CYCLES = (CLK_HZ / 1000) * SOFT_START_MS;

    // fractions of the set limit and of the period, in 1/256 units
    localparam int unsigned DUTY_CEILING_PCT = 78;
    localparam logic [7:0] DUTY_FRAC = 8'(DUTY_CEILING_PCT * 256 / 100);
    localparam int unsigned UPPER_PEAK_PCT = 55;
    localparam int unsigned LOWER_PEAK_PCT = 25;
    localparam logic [7:0] UPPER_PEAK_CODE = 8'(UPPER_PEAK_PCT * 256 / 100);
    localparam logic [7:0] LOWER_PEAK_CODE = 8'(LOWER_PEAK_PCT * 256 / 100);
    localparam logic [7:0] FULL_PEAK_CODE = 8'h00_FF;

    // mode boundaries on the excess control current code
    localparam logic [7:0] VAR_EXIT_EXCESS = 8'h00_60;
    localparam logic [7:0] LOW_EXIT_EXCESS = 8'h00_A0;
    localparam logic [7:0] MCM_EXIT_EXCESS = 8'h00_D0;
    localparam logic [12:0] VAR_SLOPE = 13'h0_010;

    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [3:0] RESTART_FINAL_COUNT = 4'hF;
    localparam logic [3:0] JITTER_SCALE_MAX = 4'hF;
    localparam logic [7:0] SS_LEVEL_MAX = 8'h00_FF;

    typedef enum logic [1:0] {
        MODE_FULL = 2'b00,
        MODE_VAR  = 2'b01,
        MODE_LOW  = 2'b10,
        MODE_MCM  = 2'b11
    } mode_type;

    typedef enum logic [1:0] {
        SEQ_OFF     = 2'b00,
        SEQ_SOFT    = 2'b01,
        SEQ_RUN     = 2'b10,
        SEQ_RESTART = 2'b11
    } seq_type;

    // value times a fraction in 1/256 units
    function automatic logic [10:0] scale8(input logic [10:0] v, input logic [7:0] f);
        logic [18:0] p;
        p = v * f;
        return p[18:8];
    endfunction : scale8

endpackage : switcher_pkg

// *** rtl/osc_link_if.sv ***
`timescale 1ns/100ps
interface osc_link_if;
    logic [10:0] base_period;
    logic [10:0] jitter_dev;
    logic [3:0] jitter_scale;
    logic cycle_start;
    logic [10:0] ramp_pos;
    logic [10:0] cur_period;

    modport timer (input base_period, input jitter_dev, input jitter_scale,
                   output cycle_start, output ramp_pos, output cur_period);
    modport control (output base_period, output jitter_dev, output jitter_scale,
                     input cycle_start, input ramp_pos, input cur_period);
endinterface : osc_link_if

// *** rtl/switch_oscillator.sv ***
`timescale 1ns/100ps
module switch_oscillator #(
    parameter int unsigned JITTER_CYCLES = switcher_pkg::JITTER_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    osc_link_if.timer link
);
    import switcher_pkg::*;

    localparam int unsigned STEP_RAW = JITTER_CYCLES / 512;
    localparam logic [19:0] JIT_STEP = 20'((STEP_RAW > 0) ? STEP_RAW - 1 : 0);

    logic [10:0] pos_q;
    logic [10:0] period_q;
    logic cycle_q;
    logic [19:0] jstep_q;
    logic [7:0] tri_q;
    logic tri_up_q;

    // jitter offset swings from -amp to +amp following the 250 Hz triangle
    wire [10:0] amp_w = scale8(link.jitter_dev, {link.jitter_scale, 4'h0});
    wire [10:0] offset_w = scale8({amp_w[9:0], 1'b0}, tri_q);
    wire [10:0] next_period_w = 11'(link.base_period + offset_w - amp_w);
    wire last_w = (pos_q >= 11'(period_q - 11'h001));
    wire jtick_w = (jstep_q == JIT_STEP);

    assign link.cycle_start = cycle_q;
    assign link.ramp_pos = pos_q;
    assign link.cur_period = period_q;

    // timing ramp; the period is latched at the wrap so a cycle never changes length midway
    always_ff @(posedge clk) begin
        if (srst) begin
            pos_q <= 11'h000;
            period_q <= PERIOD_LO;
            cycle_q <= 1'b0;
        end else if (last_w) begin
            pos_q <= 11'h000;
            period_q <= next_period_w;
            cycle_q <= 1'b1;
        end else begin
            pos_q <= 11'(pos_q + 11'h001);
            cycle_q <= 1'b0;
        end
    end

    // triangle for the frequency jitter
    always_ff @(posedge clk) begin
        if (srst) begin
            jstep_q <= 20'h0_0000;
            tri_q <= 8'h00_80;
            tri_up_q <= 1'b1;
        end else if (jtick_w) begin
            jstep_q <= 20'h0_0000;
            tri_q <= tri_up_q ? 8'(tri_q + 8'h01) : 8'(tri_q - 8'h01);
            if (tri_up_q && tri_q == 8'h00_FE) begin
                tri_up_q <= 1'b0;
            end else if (!tri_up_q && tri_q == 8'h00_01) begin
                tri_up_q <= 1'b1;
            end
        end else begin
            jstep_q <= 20'(jstep_q + 20'h0_0001);
        end
    end

endmodule : switch_oscillator

// *** rtl/multimode_switcher_controller.sv ***
`timescale 1ns/100ps
// Function
// - switch stays off after power-up; control starts at upper supply threshold with soft-start.
// - soft-start ramps peak limit and frequency from low to full over 17 ms.
// - no feedback at soft-start end turns the charger off, supply discharges.
// - supply at lower threshold enters auto-restart: switch off, standby, charging restarts.
// - in auto-restart the charger toggles on at lower, off at upper threshold.
// - sixteen-state cycle counter; switching allowed only at final count fifteen.
// - one attempt per fifteen cycles limits fault on-fraction to about two percent.
// - auto-restart repeats until feedback current returns, then normal modulation resumes.
// - oscillator ramp starts each switching cycle and sets the gate latch.
// - frequency select high gives 66 kHz, low gives default 132 kHz.
// - variant without frequency select is fixed at 66 kHz.
// - full-frequency mode jitters frequency by 2.5 or 5 kHz at 250 Hz.
// - jitter amplitude fades gradually to zero leaving full-frequency mode.
// - duty falls monotonically as excess control current rises in full and low modes; variable mode stays at the ceiling.
// - four load-selected modes: full, variable, low frequency, multi-cycle.
// - full mode shortens on-time, stays only while peak exceeds 55 percent.
// - variable mode holds peak at 55 percent, lengthens off-time toward 30 kHz.
// - at 30 kHz low mode holds frequency, shortens on-time, peak toward 25 percent.
// - multi-cycle mode bursts pulses at 30 kHz, then waits for control current to drop.
// - duty capped at 78 percent of the period in every PWM mode.
// - at final restart count, line low detect blocks switching for that cycle.
module multimode_switcher_controller #(
    parameter int unsigned SOFT_START_CYCLES = switcher_pkg::SOFT_START_CYCLES,
    parameter int unsigned JITTER_CYCLES = switcher_pkg::JITTER_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic supply_at_upper,
    input wire logic supply_at_lower,
    input wire logic feedback_present,
    input wire logic peak_above_upper,
    input wire logic peak_above_lower,
    input wire logic current_limit_trip,
    input wire logic control_below_off,
    input wire logic line_low_detect,
    input wire logic freq_select_high,
    input wire logic freq_pin_fitted,
    input wire logic [7:0] excess_current,
    output logic gate_enable,
    output logic charger_on,
    output logic standby,
    output logic [7:0] peak_limit,
    output switcher_pkg::mode_type active_mode,
    output logic [3:0] restart_count
);
    import switcher_pkg::*;

    localparam int unsigned SS_RAW = SOFT_START_CYCLES / 256;
    localparam logic [19:0] SS_TICK = 20'((SS_RAW > 0) ? SS_RAW - 1 : 0);

    osc_link_if link ();

    switch_oscillator #(
        .JITTER_CYCLES(JITTER_CYCLES)
    ) u_osc (
        .clk(clk),
        .srst(srst),
        .link(link)
    );

    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic [7:0] excess_q;
    seq_type seq_q;
    mode_type mode_q;
    logic [3:0] cnt_q;
    logic attempt_q;
    logic charger_q;
    logic standby_q;
    logic gate_q;
    logic [7:0] peak_q;
    logic [19:0] ss_cnt_q;
    logic [7:0] ss_level_q;
    logic [3:0] jit_scale_q;
    logic [10:0] on_len_q;
    logic [2:0] burst_q;
    logic peak_up_seen_q;
    logic peak_lo_seen_q;
    logic half_freq_q;

    // the first stage feeds only the second; nothing else looks at it
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end else begin
            sync1_q <= {line_low_detect, control_below_off, current_limit_trip, peak_above_lower,
                        peak_above_upper, feedback_present, supply_at_lower, supply_at_upper, 1'b0};
            sync2_q <= sync1_q;
        end
    end

    // synchronised flags
    wire upper_s = sync2_q[1];
    wire lower_s = sync2_q[2];
    wire feedback_s = sync2_q[3];
    wire peak_up_s = sync2_q[4];
    wire peak_lo_s = sync2_q[5];
    wire limit_s = sync2_q[6];
    wire below_off_s = sync2_q[7];
    wire line_low_s = sync2_q[8];
    wire cyc_w = link.cycle_start;

    // sequencing decodes
    wire ss_run_w = (seq_q == SEQ_SOFT) || (seq_q == SEQ_RESTART && attempt_q);
    wire ss_tick_w = ss_run_w && (ss_cnt_q == SS_TICK);
    wire ss_done_w = ss_tick_w && (ss_level_q == SS_LEVEL_MAX);
    wire sw_en_w = (seq_q == SEQ_SOFT) || (seq_q == SEQ_RUN) || (seq_q == SEQ_RESTART && attempt_q);
    wire charge_done_w = (seq_q == SEQ_RESTART) && charger_q && upper_s;
    wire discharge_done_w = (seq_q == SEQ_RESTART) && !charger_q && lower_s && !upper_s;

    // full period: fixed 66 kHz without the select pin, else pin chooses
    wire [10:0] full_period_w = half_freq_q ? PERIOD_LO : PERIOD_HI;
    wire [10:0] full_dev_w = half_freq_q ? JIT_DEV_LO : JIT_DEV_HI;
    wire [10:0] ss_period_w = 11'(full_period_w + scale8(11'(PERIOD_MIN_FREQ - full_period_w), ~ss_level_q));
    wire [12:0] var_raw_w = 13'(full_period_w) + 13'(excess_q - VAR_EXIT_EXCESS) * VAR_SLOPE;
    wire var_at_min_w = (excess_q >= VAR_EXIT_EXCESS) && (var_raw_w >= 13'(PERIOD_MIN_FREQ));
    wire [10:0] var_period_w = (excess_q < VAR_EXIT_EXCESS) ? full_period_w :
                               var_at_min_w ? PERIOD_MIN_FREQ : var_raw_w[10:0];

    // base period per mode; lower modes sit at the minimum frequency
    assign link.base_period = (mode_q == MODE_FULL) ? ss_period_w :
                              (mode_q == MODE_VAR) ? var_period_w : PERIOD_MIN_FREQ;
    assign link.jitter_dev = full_dev_w;
    assign link.jitter_scale = jit_scale_q;

    // duty: 78 percent ceiling, in full and low modes times a share that falls as excess current rises
    wire [10:0] ceil_w = scale8(link.cur_period, DUTY_FRAC);
    wire [10:0] on_max_w = scale8(link.base_period, DUTY_FRAC);
    wire [10:0] on_pwm_w = scale8(on_max_w, ~excess_q);
    wire [10:0] on_next_w = (mode_q == MODE_FULL || mode_q == MODE_LOW) ? on_pwm_w : on_max_w;
    wire [7:0] low_peak_w = 8'(LOWER_PEAK_CODE + scale8(11'(UPPER_PEAK_CODE - LOWER_PEAK_CODE), ~excess_q));
    wire [7:0] peak_next_w = (mode_q == MODE_FULL) ? ss_level_q :
                             (mode_q == MODE_VAR) ? UPPER_PEAK_CODE :
                             (mode_q == MODE_LOW) ? low_peak_w : LOWER_PEAK_CODE;
    wire burst_go_w = (mode_q != MODE_MCM) || (burst_q != 3'h0) || below_off_s;
    wire pulse_end_w = limit_s || (link.ramp_pos >= on_len_q) || (link.ramp_pos >= ceil_w);

    // start-up, soft-start and auto-restart sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            seq_q <= SEQ_OFF;
            cnt_q <= 4'h0;
            attempt_q <= 1'b0;
            charger_q <= 1'b1;
            standby_q <= 1'b0;
        end else begin
            case (seq_q)
                SEQ_OFF: begin
                    charger_q <= 1'b1;
                    if (upper_s) begin
                        seq_q <= SEQ_SOFT;
                    end
                end
                SEQ_SOFT, SEQ_RUN: begin
                    if (lower_s) begin
                        seq_q <= SEQ_RESTART;
                        cnt_q <= 4'h0;
                        attempt_q <= 1'b0;
                        charger_q <= 1'b1;
                        standby_q <= 1'b1;
                    end else if (ss_done_w) begin
                        seq_q <= SEQ_RUN;
                        charger_q <= feedback_s;
                    end else if (seq_q == SEQ_RUN) begin
                        charger_q <= 1'b0;
                    end
                end
                SEQ_RESTART: begin
                    if (attempt_q && feedback_s && !lower_s) begin
                        seq_q <= SEQ_RUN;
                        cnt_q <= 4'h0;
                        attempt_q <= 1'b0;
                        charger_q <= 1'b0;
                        standby_q <= 1'b0;
                    end else if (charge_done_w) begin
                        charger_q <= 1'b0;
                        cnt_q <= 4'(cnt_q + 4'h1);
                        if (cnt_q == 4'(RESTART_FINAL_COUNT - 4'h1)) begin
                            attempt_q <= !line_low_s;
                            standby_q <= line_low_s;
                        end
                    end else if (discharge_done_w) begin
                        charger_q <= 1'b1;
                        standby_q <= 1'b1;
                        attempt_q <= 1'b0;
                        if (cnt_q == RESTART_FINAL_COUNT) begin
                            cnt_q <= 4'h0;
                        end
                    end
                end
                default: begin
                    seq_q <= SEQ_OFF;
                end
            endcase
        end
    end

    // soft-start ramp, restarted at each restart attempt
    always_ff @(posedge clk) begin
        if (srst || !ss_run_w) begin
            ss_cnt_q <= 20'h0_0000;
            ss_level_q <= (seq_q == SEQ_RUN) ? SS_LEVEL_MAX : 8'h00_00;
        end else if (ss_tick_w) begin
            ss_cnt_q <= 20'h0_0000;
            ss_level_q <= (ss_level_q == SS_LEVEL_MAX) ? ss_level_q : 8'(ss_level_q + 8'h01);
        end else begin
            ss_cnt_q <= 20'(ss_cnt_q + 20'h0_0001);
        end
    end

    // frequency strap is sampled while the switch is idle, never at reset itself
    always_ff @(posedge clk) begin
        if (srst) begin
            half_freq_q <= 1'b1;
            excess_q <= 8'h00_00;
        end else begin
            excess_q <= excess_current;
            if (seq_q == SEQ_OFF) begin
                half_freq_q <= !freq_pin_fitted || freq_select_high;
            end
        end
    end

    // peak level seen during the cycle, judged at its end
    always_ff @(posedge clk) begin
        if (srst || cyc_w) begin
            peak_up_seen_q <= 1'b0;
            peak_lo_seen_q <= 1'b0;
        end else begin
            peak_up_seen_q <= peak_up_seen_q || peak_up_s;
            peak_lo_seen_q <= peak_lo_seen_q || peak_lo_s;
        end
    end

    // load-driven mode selection, only at cycle boundaries
    always_ff @(posedge clk) begin
        if (srst || !sw_en_w) begin
            mode_q <= MODE_FULL;
        end else if (cyc_w && ss_level_q == SS_LEVEL_MAX) begin
            case (mode_q)
                MODE_FULL: mode_q <= peak_up_seen_q ? MODE_FULL : MODE_VAR;
                MODE_VAR: mode_q <= (excess_q < VAR_EXIT_EXCESS) ? MODE_FULL :
                                    var_at_min_w ? MODE_LOW : MODE_VAR;
                MODE_LOW: mode_q <= (excess_q < LOW_EXIT_EXCESS) ? MODE_VAR :
                                    peak_lo_seen_q ? MODE_LOW : MODE_MCM;
                MODE_MCM: mode_q <= (excess_q < MCM_EXIT_EXCESS) ? MODE_LOW : MODE_MCM;
                default: mode_q <= MODE_FULL;
            endcase
        end
    end

    // jitter grows back in full mode and fades one step per cycle elsewhere
    always_ff @(posedge clk) begin
        if (srst) begin
            jit_scale_q <= 4'h0;
        end else if (cyc_w) begin
            if (mode_q == MODE_FULL) begin
                jit_scale_q <= (jit_scale_q == JITTER_SCALE_MAX) ? jit_scale_q : 4'(jit_scale_q + 4'h1);
            end else if (jit_scale_q != 4'h0) begin
                jit_scale_q <= 4'(jit_scale_q - 4'h1);
            end
        end
    end

    // gate latch: set at cycle start, cleared by on-time, ceiling or current limit
    always_ff @(posedge clk) begin
        if (srst || !sw_en_w) begin
            gate_q <= 1'b0;
            on_len_q <= 11'h000;
            burst_q <= 3'h0;
            peak_q <= 8'h00_00;
        end else if (cyc_w) begin
            on_len_q <= on_next_w;
            peak_q <= peak_next_w;
            gate_q <= burst_go_w && (on_next_w != 11'h000);
            if (mode_q != MODE_MCM) begin
                burst_q <= 3'h0;
            end else if (burst_q != 3'h0) begin
                burst_q <= 3'(burst_q - 3'h1);
            end else if (below_off_s) begin
                burst_q <= 3'(BURST_PULSES - 3'h1);
            end
        end else if (pulse_end_w) begin
            gate_q <= 1'b0;
        end
    end

    assign gate_enable = gate_q;
    assign charger_on = charger_q;
    assign standby = standby_q;
    assign peak_limit = peak_q;
    assign active_mode = mode_q;
    assign restart_count = cnt_q;

    power_up_off_a: assert property (@(posedge clk) disable iff (srst) seq_q == SEQ_OFF |-> !gate_q)
        else $error("gate on before supply reached upper threshold");
    soft_start_entry_a: assert property (@(posedge clk) disable iff (srst)
        seq_q == SEQ_OFF && upper_s |=> seq_q == SEQ_SOFT ##1 ss_level_q == 8'h00_00)
        else $error("soft-start did not begin at upper threshold");
    charger_cutoff_a: assert property (@(posedge clk) disable iff (srst)
        seq_q == SEQ_SOFT && ss_done_w && !feedback_s && !lower_s |=> seq_q == SEQ_RUN && !charger_q)
        else $error("charger still on after soft-start without feedback");
    restart_entry_a: assert property (@(posedge clk) disable iff (srst)
        (seq_q == SEQ_SOFT || seq_q == SEQ_RUN) && lower_s |=> (seq_q == SEQ_RESTART && standby_q) ##1 !gate_q)
        else $error("auto-restart not entered at lower threshold");
    charger_hyst_a: assert property (@(posedge clk) disable iff (srst)
        discharge_done_w && !(attempt_q && feedback_s) |=> charger_q)
        else $error("charger not restarted at lower threshold");
    final_count_gate_a: assert property (@(posedge clk) disable iff (srst)
        $rose(gate_q) && seq_q == SEQ_RESTART |-> cnt_q == RESTART_FINAL_COUNT)
        else $error("switching before final restart count");
    line_low_block_a: assert property (@(posedge clk) disable iff (srst)
        charge_done_w && cnt_q == 4'hE && line_low_s && !(attempt_q && feedback_s) |=> !attempt_q [*2])
        else $error("restart attempt despite line low");
    duty_ceiling_a: assert property (@(posedge clk) disable iff (srst) gate_q |-> link.ramp_pos <= ceil_w)
        else $error("on-time exceeds duty ceiling");
    mcm_idle_a: assert property (@(posedge clk) disable iff (srst)
        sw_en_w && cyc_w && mode_q == MODE_MCM && burst_q == 3'h0 && !below_off_s |=> !gate_q)
        else $error("burst started while control current high");
    jitter_fade_a: assert property (@(posedge clk) disable iff (srst)
        cyc_w && mode_q != MODE_FULL && jit_scale_q != 4'h0 |=> jit_scale_q == 4'($past(jit_scale_q) - 4'h1))
        else $error("jitter not fading one step per cycle");

endmodule : multimode_switcher_controller

// *** dv/front_end_model.sv ***
`timescale 1ns/100ps
module front_end_model (
    input wire logic clk,
    input wire logic charger_on,
    input wire logic feedback_present,
    input wire logic gate_enable,
    output logic supply_at_upper,
    output logic supply_at_lower,
    output logic current_limit_trip
);
    int level = 0;
    int tick = 0;
    int on_cnt = 0;
    // supply cap: charged by the source, held by feedback, else drained by the chip load
    always @(posedge clk) begin
        tick <= tick + 1;
        on_cnt <= gate_enable ? on_cnt + 1 : 0;
        if (tick % 2 == 0) begin
            if (charger_on && level < 100) level <= level + 1;
            else if (!charger_on && !feedback_present && level > 0) level <= level - 1;
        end
    end
    // window comparators with hysteresis band between 40 and 100
    assign supply_at_upper = (level >= 100);
    assign supply_at_lower = (level <= 40);
    // trips only on very long pulses, so the duty ceiling normally ends a pulse
    assign current_limit_trip = (on_cnt >= 1500);
endmodule : front_end_model

// *** dv/multimode_switcher_controller_tb_top.sv ***
`timescale 1ns/100ps
module multimode_switcher_controller_tb_top;
    import switcher_pkg::*;
    logic clk = 0, srst = 1, feedback_present = 0, peak_above_upper = 1, peak_above_lower = 1;
    logic control_below_off = 0, line_low_detect = 0, freq_select_high = 0, freq_pin_fitted = 1;
    logic [7:0] excess_current = 8'h00_00;
    logic supply_at_upper, supply_at_lower, current_limit_trip, gate_enable, charger_on, standby;
    logic [7:0] peak_limit;
    mode_type active_mode;
    logic [3:0] restart_count;
    int failures = 0, total_checks = 0, hi, per, n, mn, mx;
    always #10 clk = ~clk;
    multimode_switcher_controller #(.SOFT_START_CYCLES(2560), .JITTER_CYCLES(5120))
        multimode_switcher_controller_inst (.clk, .srst, .supply_at_upper, .supply_at_lower, .feedback_present,
        .peak_above_upper, .peak_above_lower, .current_limit_trip, .control_below_off, .line_low_detect,
        .freq_select_high, .freq_pin_fitted, .excess_current, .gate_enable, .charger_on, .standby,
        .peak_limit, .active_mode, .restart_count);
    front_end_model front_end_model_inst (.clk, .charger_on, .feedback_present, .gate_enable,
        .supply_at_upper, .supply_at_lower, .current_limit_trip);
    task automatic chk_le(input int a, input int b);
        total_checks++;
        if (a > b) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, a, b);
        end
    endtask : chk_le
    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_code
    // bounded wait on a flag, then judge it
    task automatic wait_chk(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
        chk_code(8'(s), 8'(v));
    endtask : wait_chk
    task automatic wait_mode(input mode_type m);
        for (int i = 0; i < 9000 && active_mode !== m; i++) @(negedge clk);
        chk_code(8'(active_mode), 8'(m));
    endtask : wait_mode
    // period and high time of one gate cycle, counted in clocks
    task automatic measure;
        for (n = 0; n < 4000 && gate_enable === 1'b1; n++) @(negedge clk);
        for (n = 0; n < 4000 && gate_enable !== 1'b1; n++) @(negedge clk);
        for (hi = 0; hi < 4000 && gate_enable === 1'b1; hi++) @(negedge clk);
        for (per = hi; per < 4000 && gate_enable !== 1'b1; per++) @(negedge clk);
    endtask : measure
    task automatic do_reset(input logic s, input logic f, input logic b);
        srst = 1;
        freq_select_high = s;
        freq_pin_fitted = f;
        feedback_present = b;
        repeat (8) @(negedge clk);
        srst = 0;
    endtask : do_reset
    task automatic t_power_up;
        chk_code(8'({gate_enable, charger_on}), 8'h00_01);
        wait_chk(supply_at_upper, 1, 2000);
        chk_code(8'(gate_enable), 8'h00_00);
        measure();
        chk_le(PERIOD_HI + 200, per);
        wait_chk(charger_on, 0, 3000);
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_auto_restart;
        wait_chk(standby, 1, 1000);
        repeat (2) @(negedge clk);
        chk_code(8'({gate_enable, charger_on}), 8'h00_01);
        wait_chk(charger_on, 0, 1000);
        wait_chk(charger_on, 1, 1000);
        line_low_detect = 1;
        hi = 0;
        for (n = 0; n < 12000 && restart_count !== RESTART_FINAL_COUNT; n++) begin
            @(negedge clk);
            hi += (gate_enable !== 1'b0);
        end
        chk_le(hi, 0);
        repeat (50) @(negedge clk);
        chk_code(8'({standby, gate_enable}), 8'h00_02);
        line_low_detect = 0;
        wait_chk(charger_on, 1, 1000);
        for (n = 0; n < 12000 && restart_count !== RESTART_FINAL_COUNT; n++) @(negedge clk);
        feedback_present = 1;
        wait_chk(gate_enable, 1, 4000);
        repeat (2700) @(negedge clk);
        chk_code({restart_count, 2'b00, standby, charger_on}, 8'h00_00);
        $display("test auto_restart done");
    endtask : t_auto_restart
    task automatic t_full_freq;
        mn = 4000;
        mx = 0;
        repeat (16) begin
            measure();
            mn = (per < mn) ? per : mn;
            mx = (per > mx) ? per : mx;
            chk_le(hi * 100, per * DUTY_CEILING_PCT + 100);
        end
        chk_le(PERIOD_HI - JIT_DEV_HI - 1, mn);
        chk_le(mn + 1, PERIOD_HI);
        chk_le(mx, PERIOD_HI + JIT_DEV_HI + 1);
        chk_le(mn + 1, mx);
        $display("test full_freq done");
    endtask : t_full_freq
    task automatic t_modes;
        peak_above_upper = 0;
        excess_current = 8'h00_70;
        wait_mode(MODE_VAR);
        measure();
        chk_code(peak_limit, UPPER_PEAK_CODE);
        excess_current = 8'h00_F0;
        wait_mode(MODE_LOW);
        repeat (25000) @(negedge clk);
        measure();
        chk_le(PERIOD_MIN_FREQ, per);
        chk_le(per, PERIOD_MIN_FREQ + 1);
        peak_above_lower = 0;
        wait_mode(MODE_MCM);
        repeat (2000) @(negedge clk);
        chk_code(peak_limit, LOWER_PEAK_CODE);
        control_below_off = 1;
        wait_chk(gate_enable, 1, 4000);
        control_below_off = 0;
        hi = 0;
        mn = 1;
        repeat (8000) begin
            @(negedge clk);
            hi += (gate_enable === 1'b1 && mn == 0);
            mn = (gate_enable === 1'b1);
        end
        chk_le(hi + 1, BURST_PULSES);
        chk_le(BURST_PULSES, hi + 1);
        $display("test modes done");
    endtask : t_modes
    // both straps that give the half rate; the strap is read only before start-up
    task automatic t_half_freq(input logic s, input logic f);
        peak_above_upper = 1;
        peak_above_lower = 1;
        excess_current = 8'h00_00;
        do_reset(s, f, 1);
        repeat (3000) @(negedge clk);
        measure();
        chk_le(PERIOD_LO - JIT_DEV_LO - 1, per);
        chk_le(per, PERIOD_LO + JIT_DEV_LO + 1);
        $display("test half_freq done");
    endtask : t_half_freq
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        do_reset(0, 1, 0);
        t_power_up();
        t_auto_restart();
        t_full_freq();
        t_modes();
        t_half_freq(1, 1);
        t_half_freq(0, 0);
        conclude();
    end
    // hang guard, some way above the expected run
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule : multimode_switcher_controller_tb_top
